// ### verilog/charge_counter_control.sv
/*
  Digital control and bookkeeping of a battery charge gauge: control
  register, 16-bit charge accumulator, thresholds, status and the
  dual-function alert or charge-complete pin.
  Assumes a serial-bus slave engine that issues one-cycle register strobes
  and reports a completed alert response, and an analog section whose
  events arrive synchronous to clk.
*/
`timescale 1ns/1ps
module charge_counter_control (
  input wire logic clk,  // System clock, 100 MHz.
  input wire logic sys_rst,  // Asynchronous reset, active high.
  input wire gauge_pkg::reg_req_t reg_req,  // Register access strobes.
  output logic [7:0] reg_rdata,  // Read data, valid the cycle after rd.
  input wire gauge_pkg::analog_in_t analog_in,  // Analog section events.
  output gauge_pkg::vbat_sel_t vbat_sel,  // Voltage comparator threshold.
  output logic analog_shutdown,  // Powers down the analog section.
  input wire logic ara_done,  // Pulse: alert response sent in full.
  output logic ara_respond,  // Device may answer an alert response.
  input wire logic alert_or_charge_done_pin_in,  // Pin level.
  output logic alert_or_charge_done_pin_out,  // Pin drive value, always 0.
  output logic alert_or_charge_done_pin_oe  // High while pulling the pin low.
);
  import gauge_pkg::*;

  logic [7:0] gauge_control;  // Control register.
  logic [15:0] charge_accumulator;  // Accumulated charge.
  logic [15:0] thr_high;  // High charge threshold.
  logic [15:0] thr_low;  // Low charge threshold.
  logic flag_saturate;  // Saturation flag.
  logic flag_high;  // High threshold flag.
  logic flag_low;  // Low threshold flag.
  logic flag_vbat;  // Voltage alert flag.
  logic flag_uvlo;  // Undervoltage recovery flag.
  logic alert_pending;  // An alert awaits an alert response.
  logic step;  // Accumulator step from the prescaler.
  logic step_up;  // Direction of that step.
  logic above;  // Count above high threshold.
  logic below;  // Count below low threshold.
  logic shutdown;  // Shutdown bit of the control register.
  logic alert_mode;  // Pin works as alert output.
  logic charge_done_mode;  // Pin works as charge-complete input.
  logic charge_done;  // Charge-complete input is high.
  logic vbat_cond;  // Voltage alert condition now present.
  logic sat_cond;  // Count sits at a limit.
  logic sat_event;  // A step hits or pushes against a limit.
  logic status_read;  // Host reads the status register.
  logic [7:0] status_value;  // Assembled status byte.
  logic new_alert;  // A flag other than undervoltage becomes set this cycle.

  // Control field decoding.
  assign shutdown = gauge_control[CTRL_SHUTDOWN];
  // Exact decode; the forbidden pin mode 11 falls to neither function.
  assign alert_mode = (gauge_control[CTRL_PIN_HI:CTRL_PIN_LO] == PIN_ALERT);
  assign charge_done_mode = (gauge_control[CTRL_PIN_HI:CTRL_PIN_LO] == PIN_CHARGE_DONE);
  assign charge_done = charge_done_mode && alert_or_charge_done_pin_in;

  // Voltage alert counts only when a threshold is selected.
  assign vbat_cond = (gauge_control[CTRL_VBAT_HI:CTRL_VBAT_LO] != VBAT_OFF)
                     && analog_in.vbat_below;

  // Saturation: the count sits at a limit, or a step reaches one.
  assign sat_cond = (charge_accumulator == COUNT_FULL)
                    || (charge_accumulator == COUNT_EMPTY);
  assign sat_event = step && !charge_done
                     && ((step_up && charge_accumulator >= (COUNT_FULL - 16'h0001))
                     || (!step_up && charge_accumulator <= (COUNT_EMPTY + 16'h0001)));

  assign status_read = reg_req.rd && (reg_req.addr == ADDR_STATUS);

  // A flag other than undervoltage rising from clear to set is a new alert event.
  assign new_alert = (sat_event && !flag_saturate) || (above && !flag_high)
                     || (below && !flag_low) || (vbat_cond && !flag_vbat);

  // Status byte, reserved bits read as zero.
  always_comb begin
    status_value = 8'h00;
    status_value[STAT_CHIP_ID] = CHIP_ID_VALUE;
    status_value[STAT_SATURATE] = flag_saturate;
    status_value[STAT_CHARGE_HIGH] = flag_high;
    status_value[STAT_CHARGE_LOW] = flag_low;
    status_value[STAT_VBAT] = flag_vbat;
    status_value[STAT_UVLO] = flag_uvlo;
  end

  // The prescaler only sees pulses while the analog section is on.
  charge_prescaler u_prescaler (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(shutdown || charge_done),
    .pulse_in(analog_in.count_pulse && !shutdown),
    .up_in(analog_in.count_up),
    .exponent(gauge_control[CTRL_PRESC_HI:CTRL_PRESC_LO]),
    .step(step),
    .step_up(step_up)
  );

  // Threshold compare against the live count.
  charge_compare u_compare (
    .clk(clk),
    .sys_rst(sys_rst),
    .count(charge_accumulator),
    .thr_high(thr_high),
    .thr_low(thr_low),
    .above(above),
    .below(below)
  );

  // Control register: written by the host, reset to alert mode, factor 128.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gauge_control <= CONTROL_RESET;
    end else if (reg_req.wr && reg_req.addr == ADDR_CONTROL) begin
      gauge_control <= reg_req.wdata;
    end
  end

  // Accumulator: host write first, then charge-complete preset, then steps.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      charge_accumulator <= COUNT_RESET;
    end else if (reg_req.wr && reg_req.addr == ADDR_COUNT_HIGH) begin
      // The host writes each byte alone; the other byte stays.
      charge_accumulator[15:8] <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == ADDR_COUNT_LOW) begin
      charge_accumulator[7:0] <= reg_req.wdata;
    end else if (charge_done) begin
      // Charger reports a full battery; counting resumes once it is low.
      charge_accumulator <= COUNT_FULL;
    end else if (step && !shutdown) begin
      // Steps stop at the limits instead of wrapping.
      if (step_up && charge_accumulator != COUNT_FULL) begin
        charge_accumulator <= charge_accumulator + 16'h0001;
      end else if (!step_up && charge_accumulator != COUNT_EMPTY) begin
        charge_accumulator <= charge_accumulator - 16'h0001;
      end
    end
  end

  // Threshold registers, one byte per address.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      thr_high <= THR_HIGH_RESET;
      thr_low <= THR_LOW_RESET;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_THR_HIGH_MSB: begin
          thr_high[15:8] <= reg_req.wdata;
        end
        ADDR_THR_HIGH_LSB: begin
          thr_high[7:0] <= reg_req.wdata;
        end
        ADDR_THR_LOW_MSB: begin
          thr_low[15:8] <= reg_req.wdata;
        end
        ADDR_THR_LOW_LSB: begin
          thr_low[7:0] <= reg_req.wdata;
        end
        default: begin
          // Other addresses leave the thresholds alone.
        end
      endcase
    end
  end

  // Sticky status flags. A set in the same cycle as a read wins, and a
  // read only clears a flag whose cause has gone.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_saturate <= 1'b0;
      flag_high <= 1'b0;
      flag_low <= 1'b0;
      flag_vbat <= 1'b0;
      flag_uvlo <= 1'b0;
    end else begin
      if (sat_event) begin
        flag_saturate <= 1'b1;
      end else if (status_read && !sat_cond) begin
        flag_saturate <= 1'b0;
      end
      if (above) begin
        flag_high <= 1'b1;
      end else if (status_read) begin
        flag_high <= 1'b0;
      end
      if (below) begin
        flag_low <= 1'b1;
      end else if (status_read) begin
        flag_low <= 1'b0;
      end
      if (vbat_cond) begin
        flag_vbat <= 1'b1;
      end else if (status_read) begin
        flag_vbat <= 1'b0;
      end
      if (analog_in.uvlo_event) begin
        flag_uvlo <= 1'b1;
      end else if (status_read) begin
        flag_uvlo <= 1'b0;
      end
    end
  end

  // Alert latch: set by a new event, cleared by a finished alert response or outside alert mode.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_pending <= 1'b0;
    end else if (new_alert) begin
      alert_pending <= 1'b1;
    end else if (ara_done || !alert_mode) begin
      alert_pending <= 1'b0;
    end
  end

  // Pin and alert response outputs, registered.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_or_charge_done_pin_out <= 1'b0;
      alert_or_charge_done_pin_oe <= 1'b0;
      ara_respond <= 1'b0;
    end else begin
      // Open drain: the pin only ever pulls low.
      alert_or_charge_done_pin_out <= 1'b0;
      alert_or_charge_done_pin_oe <= alert_mode && alert_pending && !ara_done;
      ara_respond <= alert_mode && alert_pending && !ara_done;
    end
  end

  // Analog section controls.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vbat_sel <= VBAT_OFF;
      analog_shutdown <= 1'b0;
    end else begin
      vbat_sel <= vbat_sel_t'(gauge_control[CTRL_VBAT_HI:CTRL_VBAT_LO]);
      analog_shutdown <= shutdown;
    end
  end

  // Read data: registered, unmapped addresses read zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_STATUS: begin
          reg_rdata <= status_value;
        end
        ADDR_CONTROL: begin
          reg_rdata <= gauge_control;
        end
        ADDR_COUNT_HIGH: begin
          reg_rdata <= charge_accumulator[15:8];
        end
        ADDR_COUNT_LOW: begin
          reg_rdata <= charge_accumulator[7:0];
        end
        ADDR_THR_HIGH_MSB: begin
          reg_rdata <= thr_high[15:8];
        end
        ADDR_THR_HIGH_LSB: begin
          reg_rdata <= thr_high[7:0];
        end
        ADDR_THR_LOW_MSB: begin
          reg_rdata <= thr_low[15:8];
        end
        ADDR_THR_LOW_LSB: begin
          reg_rdata <= thr_low[7:0];
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule  // charge_counter_control

// ### verilog/gauge_pkg.sv
/*
  Shared constants and carrier types for the charge gauge control block.
  Assumes a single 100 MHz system clock and a register port driven by a
  serial-bus slave engine outside this block.
*/
package gauge_pkg;

  // Register addresses as seen through the serial-bus register pointer.
  localparam logic [7:0] ADDR_STATUS = 8'h00;  // Status, read only.
  localparam logic [7:0] ADDR_CONTROL = 8'h01;  // Gauge control.
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h02;  // Charge count high byte.
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h03;  // Charge count low byte.
  localparam logic [7:0] ADDR_THR_HIGH_MSB = 8'h04;  // High threshold, high byte.
  localparam logic [7:0] ADDR_THR_HIGH_LSB = 8'h05;  // High threshold, low byte.
  localparam logic [7:0] ADDR_THR_LOW_MSB = 8'h06;  // Low threshold, high byte.
  localparam logic [7:0] ADDR_THR_LOW_LSB = 8'h07;  // Low threshold, low byte.

  // Control register field positions.
  localparam int CTRL_VBAT_HI = 7;  // Voltage alert select, top bit.
  localparam int CTRL_VBAT_LO = 6;  // Voltage alert select, bottom bit.
  localparam int CTRL_PRESC_HI = 5;  // Prescaler exponent, top bit.
  localparam int CTRL_PRESC_LO = 3;  // Prescaler exponent, bottom bit.
  localparam int CTRL_PIN_HI = 2;  // Pin mode, top bit (alert only in mode 10).
  localparam int CTRL_PIN_LO = 1;  // Pin mode, bottom bit.
  localparam int CTRL_SHUTDOWN = 0;  // Analog shutdown bit.

  // Status register field positions.
  localparam int STAT_CHIP_ID = 7;  // Hard-coded identification bit.
  localparam int STAT_SATURATE = 5;  // Count hit top or bottom.
  localparam int STAT_CHARGE_HIGH = 3;  // Count above high threshold.
  localparam int STAT_CHARGE_LOW = 2;  // Count below low threshold.
  localparam int STAT_VBAT = 1;  // Battery below voltage threshold.
  localparam int STAT_UVLO = 0;  // Recovery from undervoltage.

  // Identification bit value; the value is arbitrary.
  localparam logic CHIP_ID_VALUE = 1'b1;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h3c;  // Alert mode, factor 128.
  localparam logic [15:0] COUNT_RESET = 16'h7fff;  // Mid-scale charge.
  localparam logic [15:0] COUNT_FULL = 16'hffff;  // Top of scale.
  localparam logic [15:0] COUNT_EMPTY = 16'h0000;  // Bottom of scale.
  localparam logic [15:0] THR_HIGH_RESET = 16'hffff;  // High threshold reset.
  localparam logic [15:0] THR_LOW_RESET = 16'h0000;  // Low threshold reset.

  // Voltage alert threshold selections.
  typedef enum logic [1:0] {
    VBAT_OFF = 2'b00,  // Voltage alert disabled.
    VBAT_2V8 = 2'b01,  // 2.8 V threshold.
    VBAT_2V9 = 2'b10,  // 2.9 V threshold.
    VBAT_3V0 = 2'b11  // 3.0 V threshold.
  } vbat_sel_t;

  // Pin modes of the dual-function pin.
  typedef enum logic [1:0] {
    PIN_DISABLED = 2'b00,  // Pin unused.
    PIN_CHARGE_DONE = 2'b01,  // Pin is a charge-complete input.
    PIN_ALERT = 2'b10,  // Pin is an open-drain alert output.
    PIN_BOTH = 2'b11  // Forbidden setting.
  } pin_mode_t;

  // Register access request from the serial-bus slave engine.
  typedef struct packed {
    logic wr;  // One-cycle write strobe.
    logic rd;  // One-cycle read strobe.
    logic [7:0] addr;  // Register pointer.
    logic [7:0] wdata;  // Write data.
  } reg_req_t;

  // Events from the analog section, synchronous to clk.
  typedef struct packed {
    logic count_pulse;  // One-cycle integrator reversal pulse.
    logic count_up;  // Direction of that pulse, 1 = charge.
    logic vbat_below;  // Battery below the selected threshold.
    logic uvlo_event;  // One-cycle pulse on undervoltage recovery.
  } analog_in_t;

endpackage

// ### verilog/charge_prescaler.sv
/*
  Prescaler that divides integrator reversal pulses by 2^exp, counting up
  or down. Assumes pulses are synchronous to clk and at most one per cycle.
*/
`timescale 1ns/1ps
module charge_prescaler (
  input wire logic clk,  // System clock.
  input wire logic sys_rst,  // Asynchronous reset, active high.
  input wire logic clear,  // Discards the residue while high.
  input wire logic pulse_in,  // Integrator reversal pulse.
  input wire logic up_in,  // Direction of pulse_in.
  input wire logic [2:0] exponent,  // Prescale exponent.
  output logic step,  // One-cycle step of the accumulator.
  output logic step_up  // Direction of step.
);
  import gauge_pkg::*;

  logic [6:0] residue;  // Sub-count charge below one accumulator step.
  logic [6:0] limit;  // Largest residue for the current factor.

  // Factor minus one, so a factor of one steps on every pulse.
  assign limit = 7'((8'h01 << exponent) - 8'h01);

  // Residue counts in the pulse direction and wraps at the factor.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      residue <= 7'h00;
      step <= 1'b0;
      step_up <= 1'b0;
    end else begin
      step <= 1'b0;
      if (clear) begin
        // Shutdown loses any partial count.
        residue <= 7'h00;
      end else if (pulse_in) begin
        step_up <= up_in;
        if (up_in) begin
          // Overflow of the prescaler steps the count up.
          if (residue >= limit) begin
            residue <= 7'h00;
            step <= 1'b1;
          end else begin
            residue <= residue + 7'h01;
          end
        end else begin
          // Underflow steps the count down.
          if (residue == 7'h00) begin
            residue <= limit;
            step <= 1'b1;
          end else begin
            residue <= residue - 7'h01;
          end
        end
      end
    end
  end

endmodule  // charge_prescaler

// ### verilog/charge_compare.sv
/*
  Registered compare of the charge count against both thresholds.
  Assumes all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module charge_compare (
  input wire logic clk,  // System clock.
  input wire logic sys_rst,  // Asynchronous reset, active high.
  input wire logic [15:0] count,  // Charge count.
  input wire logic [15:0] thr_high,  // High threshold.
  input wire logic [15:0] thr_low,  // Low threshold.
  output logic above,  // Count exceeds the high threshold.
  output logic below  // Count is under the low threshold.
);
  import gauge_pkg::*;

  // Compare runs every cycle, so the result lags the count by one cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      above <= 1'b0;
      below <= 1'b0;
    end else begin
      above <= (count > thr_high);
      below <= (count < thr_low);
    end
  end

endmodule  // charge_compare

// ### sim/gauge_checker_sva.sv
/*
  Port checker of the charge gauge control block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module gauge_checker (
  input wire logic clk,  // System clock.
  input wire logic sys_rst,  // Reset, active high.
  input wire gauge_pkg::reg_req_t reg_req,  // Register strobes.
  input wire logic [7:0] reg_rdata,  // Read data.
  input wire gauge_pkg::analog_in_t analog_in,  // Analog events.
  input wire gauge_pkg::vbat_sel_t vbat_sel,  // Voltage select.
  input wire logic analog_shutdown,  // Shutdown output.
  input wire logic ara_done,  // Alert response finished.
  input wire logic ara_respond,  // Alert response enable.
  input wire logic alert_or_charge_done_pin_in,  // Pin level.
  input wire logic alert_or_charge_done_pin_out,  // Pin drive value.
  input wire logic alert_or_charge_done_pin_oe  // Pin pull enable.
);
  import gauge_pkg::*;
  // All checks share the one clock and the one reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_vbat_follows_write: assert property (
    reg_req.wr && reg_req.addr == ADDR_CONTROL |-> ##2 vbat_sel == $past(reg_req.wdata[7:6], 2))
    else $error("voltage select does not follow a control write");
  a_shutdown_follows_write: assert property (
    reg_req.wr && reg_req.addr == ADDR_CONTROL
      |-> ##2 analog_shutdown == $past(reg_req.wdata[0], 2))
    else $error("shutdown output does not follow a control write");
  a_pin_drives_low: assert property (alert_or_charge_done_pin_out == 1'b0)
    else $error("pin drive value is not low");
  a_oe_with_respond: assert property (alert_or_charge_done_pin_oe == ara_respond)
    else $error("pin pull and alert answer disagree");
  a_alert_released: assert property (ara_done |-> ##[1:2] !alert_or_charge_done_pin_oe)
    else $error("pin still pulled after the alert response");
  a_quiet_after_reset: assert property (
    $fell(sys_rst) |-> !alert_or_charge_done_pin_oe [*3])
    else $error("pin pulled right after reset");
  a_status_fixed_bits: assert property (
    reg_req.rd && reg_req.addr == ADDR_STATUS |=> reg_rdata[7] == CHIP_ID_VALUE
      && reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0)
    else $error("status fixed bits wrong");
  a_unmapped_zero: assert property (
    reg_req.rd && reg_req.addr > ADDR_THR_LOW_LSB |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule  // gauge_checker

bind charge_counter_control gauge_checker u_gauge_checker (
  .clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .analog_in(analog_in), .vbat_sel(vbat_sel), .analog_shutdown(analog_shutdown),
  .ara_done(ara_done), .ara_respond(ara_respond),
  .alert_or_charge_done_pin_in(alert_or_charge_done_pin_in),
  .alert_or_charge_done_pin_out(alert_or_charge_done_pin_out),
  .alert_or_charge_done_pin_oe(alert_or_charge_done_pin_oe));

// ### sim/gauge_host_model.sv
/*
  Host and charger model at the far side of the gauge pin.
  Assumes one clock; the pin has a pull-up to the high level.
*/
`timescale 1ns/1ps
module gauge_host_model #(
  parameter int ARA_DELAY = 30  // Cycles the host takes to answer an alert.
) (
  input wire logic clk,  // System clock.
  input wire logic sys_rst,  // Reset, active high.
  input wire logic ara_respond,  // Device asks to answer an alert.
  input wire logic pin_oe,  // Device pulls the pin low.
  input wire logic charger_on,  // Charger drives the pin.
  input wire logic charge_full,  // Charger sees a full battery.
  output logic ara_done,  // Alert response sent in full.
  output logic pin_level  // Resolved pin level.
);
  int wait_cnt;  // Cycles the pending alert has waited.
  // Device pull-down wins, then the charger, else the pull-up holds high.
  assign pin_level = pin_oe ? 1'b0 : (charger_on ? charge_full : 1'b1);
  // The host runs the alert response a while after the device asks.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt <= 0;
      ara_done <= 1'b0;
    end else begin
      ara_done <= 1'b0;
      if (ara_respond && !ara_done) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt == ARA_DELAY) begin
          ara_done <= 1'b1;
          wait_cnt <= 0;
        end
      end else begin
        wait_cnt <= 0;
      end
    end
  end
endmodule  // gauge_host_model

// ### sim/tb.sv
/*
  Testbench of the charge gauge control block, driven by register calls.
  Assumes the checker is bound to the design and the host model answers.
*/
`timescale 1ns/1ps
module tb;
  import gauge_pkg::*;
  logic clk = 1'b0;  // System clock.
  logic sys_rst = 1'b1;  // Reset, active high.
  reg_req_t reg_req = '0;  // Register strobes.
  analog_in_t analog_in = '0;  // Analog events.
  logic [7:0] reg_rdata;  // Read data.
  vbat_sel_t vbat_sel;  // Voltage select.
  logic analog_shutdown;  // Shutdown output.
  logic ara_done;  // Alert response finished.
  logic ara_respond;  // Alert answer enable.
  logic pin_level;  // Resolved pin level.
  logic pin_oe;  // Device pulls the pin.
  logic charger_on = 1'b0;  // Charger drives the pin.
  logic charge_full = 1'b0;  // Charger level.
  int fails = 0;  // Mismatches.
  int checked = 0;  // Comparisons.
  logic [7:0] rd_val;  // Last read value.
  logic [7:0] rst_tab [9] = '{8'h80, 8'h3c, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

  charge_counter_control u_charge_counter_control (.clk(clk), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .analog_in(analog_in), .vbat_sel(vbat_sel),
    .analog_shutdown(analog_shutdown), .ara_done(ara_done), .ara_respond(ara_respond),
    .alert_or_charge_done_pin_in(pin_level), .alert_or_charge_done_pin_out(),
    .alert_or_charge_done_pin_oe(pin_oe));
  gauge_host_model u_gauge_host_model (.clk(clk), .sys_rst(sys_rst), .ara_respond(ara_respond),
    .pin_oe(pin_oe), .charger_on(charger_on), .charge_full(charge_full), .ara_done(ara_done),
    .pin_level(pin_level));

  // Clock at 100 MHz.
  initial begin
    forever #5 clk = ~clk;
  end

  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One register write, strobe held for one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    reg_req <= '0;
  endtask
  // One register read; data is settled just after the taking edge.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1;
    rd_val = reg_rdata;
    check(what, rd_val, exp);
  endtask
  // Loads the count under shutdown, then restores the control value.
  task automatic cnt(input logic [15:0] v, input logic [7:0] ctl);
    wr(ADDR_CONTROL, ctl | 8'h01);
    wr(ADDR_COUNT_HIGH, v[15:8]);
    wr(ADDR_COUNT_LOW, v[7:0]);
    wr(ADDR_CONTROL, ctl);
  endtask
  // Sends integrator reversal pulses, then lets the count settle.
  task automatic pulse(input int n, input logic up);
    repeat (n) begin
      @(posedge clk);
      analog_in.count_pulse <= 1'b1;
      analog_in.count_up <= up;
      @(posedge clk);
      analog_in.count_pulse <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  // Waits a bounded time for the pin pull to reach a level.
  task automatic wait_oe(input logic exp);
    int n;
    n = 0;
    while (pin_oe !== exp && n < 80) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("pin pull", pin_oe, exp);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (10000) @(posedge clk);
    fails++;
    $display("unexpected timeout");
    give_verdict();
  end

  // Main sequence; pin mode 11 is never written.
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    wr(ADDR_STATUS, 8'hff);
    for (int i = 0; i < 9; i++) begin
      rdc(8'(i), rst_tab[i], "reset value");
    end
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_CONTROL, {v[1:0], 6'h00});
      @(posedge clk);
      #1;
      check("vbat_sel", vbat_sel, v[1:0]);
    end
    for (int e = 0; e < 4; e += 3) begin
      cnt(16'h1000, {2'b00, 3'(e), 3'b000});
      pulse((1 << e) - 1, 1'b1);
      rdc(ADDR_COUNT_LOW, 8'h00, "count before factor");
      pulse(1, 1'b1);
      rdc(ADDR_COUNT_LOW, 8'h01, "count at factor");
      pulse(1, 1'b0);
      rdc(ADDR_COUNT_LOW, 8'h00, "count down");
    end
    cnt(16'h2000, 8'h18);
    pulse(5, 1'b1);
    wr(ADDR_CONTROL, 8'h19);
    pulse(3, 1'b1);
    check("shutdown out", analog_shutdown, 1'b1);
    rdc(ADDR_CONTROL, 8'h19, "control kept");
    wr(ADDR_CONTROL, 8'h18);
    pulse(7, 1'b1);
    rdc(ADDR_COUNT_LOW, 8'h00, "residue dropped");
    pulse(1, 1'b1);
    rdc(ADDR_COUNT_LOW, 8'h01, "count resumed");
    cnt(16'hfffe, 8'h04);
    pulse(2, 1'b1);
    rdc(ADDR_COUNT_LOW, 8'hff, "saturated");
    wait_oe(1'b1);
    wait_oe(1'b0);
    rdc(ADDR_STATUS, 8'ha0, "saturation flag");
    rdc(ADDR_STATUS, 8'ha0, "flag kept at limit");
    pulse(1, 1'b0);
    rdc(ADDR_STATUS, 8'ha0, "flag until read");
    rdc(ADDR_STATUS, 8'h80, "flag cleared");
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_THR_HIGH_MSB, 8'h10);
    wr(ADDR_THR_HIGH_LSB, 8'h00);
    rdc(ADDR_THR_HIGH_MSB, 8'h10, "high threshold");
    cnt(16'h1001, 8'h00);
    rdc(ADDR_STATUS, 8'h88, "high flag");
    wr(ADDR_THR_LOW_MSB, 8'h10);
    cnt(16'h0800, 8'h00);
    rdc(ADDR_STATUS, 8'h8c, "low flag");
    rdc(ADDR_STATUS, 8'h84, "high flag cleared");
    check("pin off", pin_oe, 1'b0);
    @(posedge clk);
    charger_on <= 1'b1;
    charge_full <= 1'b1;
    wr(ADDR_CONTROL, 8'h02);
    repeat (4) @(posedge clk);
    rdc(ADDR_COUNT_HIGH, 8'hff, "preset high");
    rdc(ADDR_COUNT_LOW, 8'hff, "preset low");
    @(posedge clk);
    charge_full <= 1'b0;
    pulse(1, 1'b0);
    rdc(ADDR_COUNT_LOW, 8'hfe, "count after preset");
    check("pin input", pin_oe, 1'b0);
    @(posedge clk);
    charger_on <= 1'b0;
    analog_in.vbat_below <= 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    repeat (4) @(posedge clk);
    rdc(ADDR_STATUS, 8'h8c, "vbat off");
    wr(ADDR_CONTROL, 8'h44);
    repeat (4) @(posedge clk);
    rdc(ADDR_STATUS, 8'h8a, "vbat flag");
    wait_oe(1'b1);
    wait_oe(1'b0);
    // Undervoltage recovery sets bit zero without any alert.
    @(posedge clk);
    analog_in.uvlo_event <= 1'b1;
    @(posedge clk);
    analog_in.uvlo_event <= 1'b0;
    rdc(ADDR_STATUS, 8'h8b, "undervoltage flag");
    rdc(ADDR_STATUS, 8'h8a, "undervoltage cleared");
    check("no alert on undervoltage", pin_oe, 1'b0);
    give_verdict();
  end
endmodule  // tb
